//--- logic/asfi_pkg.sv
// Purpose: Shared constants and types of the serial frame interface of an eight-channel converter.
// Assumes: clk at 250 MHz; serial clock made by the host end from clk.
// Notes:   Control word layout and power-mode codes are used by the converter end and the testbench.
package asfi_pkg;
   localparam int          ASFI_WORD_BITS  = 16;
   localparam int          ASFI_DATA_BITS  = 12;
   localparam int          ASFI_CHAN_BITS  = 3;
   localparam int          ASFI_CTRL_BITS  = 12;
   localparam int          ASFI_NUM_CHAN   = 8;

   // Serial clock falling-edge counts
   localparam logic [4:0]  ASFI_EDGE_TRACK = 5'h0E;
   localparam logic [4:0]  ASFI_EDGE_LAST  = 5'h10;

   // Control word fields, bit 11 is the write flag
   localparam int          ASFI_CTRL_WRITE = 11;
   localparam int          ASFI_CTRL_SEQ   = 10;
   localparam int          ASFI_CTRL_SHDW  = 9;
   localparam int          ASFI_CTRL_ADDR  = 6;
   localparam int          ASFI_CTRL_PM    = 4;
   localparam logic [1:0]  ASFI_PM_NORMAL  = 2'h3;
   localparam logic [1:0]  ASFI_PM_FULL    = 2'h2;
   localparam logic [1:0]  ASFI_PM_AUTO    = 2'h1;
   localparam logic [11:0] ASFI_CTRL_RESET = 12'h030;
   localparam logic [15:0] ASFI_SHDW_RESET = 16'h0000;

   // Timing
   localparam int          ASFI_CLK_NS      = 4;
   localparam int          ASFI_QUIET_NS    = 50;
   localparam int          ASFI_CONV_MIN_NS = 5000;
   localparam int          ASFI_QUIET_CYC   = (ASFI_QUIET_NS + ASFI_CLK_NS - 1) / ASFI_CLK_NS;
   localparam int          ASFI_CONV_CYC    = (ASFI_CONV_MIN_NS + ASFI_CLK_NS - 1) / ASFI_CLK_NS;
   localparam logic [3:0]  ASFI_SCLK_HALF   = 4'h8;

   typedef enum logic [2:0] {
      ASFI_H_IDLE  = 3'b000,
      ASFI_H_HIGH  = 3'b001,
      ASFI_H_LOW   = 3'b010,
      ASFI_H_END   = 3'b011,
      ASFI_H_QUIET = 3'b100
   } asfi_hstate_t;
endpackage : asfi_pkg

//--- logic/asfi_if.sv
// Purpose: Four-wire serial link between host and converter ends.
// Assumes: Data output line idles high when undriven (weak pull-up).
// Notes:   sdo_level is the resolved line level seen by the host.
`timescale 1ns/1ps
`default_nettype none
interface asfi_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic dout;
   logic dout_oe;
   logic sdo_level;

   assign sdo_level = dout_oe ? dout : 1'b1;

   modport dev  (input cs_n, input sclk, input din, output dout, output dout_oe);
   modport host (output cs_n, output sclk, output din, input sdo_level);
endinterface : asfi_if
`default_nettype wire

//--- logic/asfi_device.sv
// Purpose: Converter end of the serial frame interface: framing, hold/track, control and shadow writes.
// Assumes: Link pins are asynchronous to clk and pass two flip-flops; sample_data is the value of mux_chan.
// Notes:   One frame = chip select low, sixteen serial clock falling edges, chip select high.
// How it works
// - serial clock drives conversion and data movement
// - select fall: hold, sample, drive output
// - conversion needs sixteen serial clocks
// - track at edge 14, shadow frame at rise
// - output floats at sixteenth falling edge
// - early rise aborts, floats, keeps control
// - word: zero, channel tag, twelve bits
// - zero at select fall, tag MSB first
// - last bit from edge 15 to 16
// - write flag loads control from twelve bits
// - shadow select captures next sixteen bits
// - single sequence uses zero low byte
// - shadow updates at rise, tracks first channel
// - host spaces conversions, quiet after writes
// - powered down needs power-up write first
// - extra write frame leaves output undriven; code drives it unless powered down
// - each select fall advances the sequence
// - host frames at equal intervals; host enforces only a minimum spacing between conversions
// - host waits quiet gap before next select
// - dummy frames send write flag zero
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module asfi_device
   import asfi_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   asfi_if.dev                            link,
   input  wire logic [ASFI_DATA_BITS-1:0] sample_data,
   output logic      [ASFI_CHAN_BITS-1:0] mux_chan,
   output logic                           track,
   output logic      [ASFI_CTRL_BITS-1:0] ctrl_word,
   output logic      [ASFI_WORD_BITS-1:0] shadow_word,
   output logic                           seq_active,
   output logic                           frame_done,
   output logic                           frame_abort
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Next set channel after cur, wrapping; cur when mask is empty
   function automatic logic [ASFI_CHAN_BITS-1:0] next_chan(
      input logic [ASFI_NUM_CHAN-1:0]  mask,
      input logic [ASFI_CHAN_BITS-1:0] cur
   );
      logic [ASFI_CHAN_BITS-1:0] cand;
      logic                      found;
      cand  = cur;
      found = 1'b0;
      next_chan = cur;
      for (int i = 1; i <= ASFI_NUM_CHAN; i++) begin
         cand = cur + i[ASFI_CHAN_BITS-1:0];
         if (!found && mask[cand]) begin
            next_chan = cand;
            found     = 1'b1;
         end
      end
   endfunction : next_chan

   function automatic logic [ASFI_NUM_CHAN-1:0] seq_mask(input logic [ASFI_WORD_BITS-1:0] sh);
      seq_mask = sh[ASFI_WORD_BITS-1 -: ASFI_NUM_CHAN] | sh[ASFI_NUM_CHAN-1:0];
   endfunction : seq_mask

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection

   logic cs_s1;
   logic cs_s2;
   logic cs_d;
   logic sclk_s1;
   logic sclk_s2;
   logic sclk_d;
   logic din_s1;
   logic din_s2;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_s1   <= 1'b1;
         cs_s2   <= 1'b1;
         cs_d    <= 1'b1;
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_d  <= 1'b1;
         din_s1  <= 1'b0;
         din_s2  <= 1'b0;
      end else begin
         cs_s1   <= link.cs_n;
         cs_s2   <= cs_s1;
         cs_d    <= cs_s2;
         sclk_s1 <= link.sclk;
         sclk_s2 <= sclk_s1;
         sclk_d  <= sclk_s2;
         din_s1  <= link.din;
         din_s2  <= din_s1;
      end
   end

   logic                      cs_fall;
   logic                      cs_rise;
   logic                      in_frame;
   logic [4:0]                nfall;
   logic                      sclk_fall;
   logic                      full;

   assign cs_fall   = cs_d & ~cs_s2;
   assign cs_rise   = ~cs_d & cs_s2;
   assign sclk_fall = sclk_d & ~sclk_s2 & ~cs_s2 & in_frame & (nfall != ASFI_EDGE_LAST);
   assign full      = (nfall == ASFI_EDGE_LAST);

   ////////////////////////////////////////////////////////////////////////////////
   // Frame tracking

   logic                      shadow_frame;
   logic                      shadow_pending;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         in_frame     <= 1'b0;
         nfall        <= 5'h00;
         shadow_frame <= 1'b0;
      end else if (cs_fall) begin
         in_frame     <= 1'b1;
         nfall        <= 5'h00;
         shadow_frame <= shadow_pending;
      end else if (cs_rise) begin
         in_frame     <= 1'b0;
      end else if (sclk_fall) begin
         nfall        <= nfall + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial output

   logic [ASFI_WORD_BITS-1:0] out_word;
   logic                      dout_r;
   logic                      oe_r;
   logic                      powered_down;

   assign powered_down = (ctrl_word[ASFI_CTRL_PM +: 2] == ASFI_PM_FULL);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_word <= '0;
         dout_r   <= 1'b0;
         oe_r     <= 1'b0;
      end else if (cs_fall) begin
         out_word <= {1'b0, mux_chan, sample_data};
         dout_r   <= 1'b0;
         oe_r     <= ~powered_down;
      end else if (cs_rise) begin
         oe_r     <= 1'b0;
      end else if (sclk_fall) begin
         if (nfall == ASFI_EDGE_LAST - 5'h01) begin
            oe_r <= 1'b0;
         end else begin
            dout_r   <= out_word[ASFI_WORD_BITS-2];
            out_word <= {out_word[ASFI_WORD_BITS-2:0], 1'b0};
         end
      end
   end

   assign link.dout    = dout_r;
   assign link.dout_oe = oe_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial input capture

   logic [ASFI_WORD_BITS-1:0] in_word;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         in_word <= '0;
      end else if (sclk_fall) begin
         in_word <= {in_word[ASFI_WORD_BITS-2:0], din_s2};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control, shadow and sequencer

   logic [ASFI_CTRL_BITS-1:0] new_ctrl;
   assign new_ctrl = in_word[ASFI_WORD_BITS-1 -: ASFI_CTRL_BITS];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_word      <= ASFI_CTRL_RESET;
         shadow_word    <= ASFI_SHDW_RESET;
         shadow_pending <= 1'b0;
         seq_active     <= 1'b0;
         mux_chan       <= '0;
      end else if (cs_fall) begin
         if (seq_active) begin
            mux_chan <= next_chan(seq_mask(shadow_word), mux_chan);
         end
      end else if (cs_rise && full) begin
         if (shadow_frame) begin
            shadow_word    <= in_word;
            shadow_pending <= 1'b0;
            seq_active     <= 1'b1;
            mux_chan       <= next_chan(seq_mask(in_word), 3'h7);
         end else if (new_ctrl[ASFI_CTRL_WRITE]) begin
            ctrl_word      <= new_ctrl;
            shadow_pending <= new_ctrl[ASFI_CTRL_SHDW];
            if (!new_ctrl[ASFI_CTRL_SEQ]) begin
               seq_active <= 1'b0;
               mux_chan   <= new_ctrl[ASFI_CTRL_ADDR +: ASFI_CHAN_BITS];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Track and hold

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         track <= 1'b1;
      end else if (cs_fall) begin
         track <= 1'b0;
      end else if (cs_rise) begin
         track <= 1'b1;
      end else if (sclk_fall && !shadow_frame && nfall == ASFI_EDGE_TRACK - 5'h01) begin
         track <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame status pulses

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frame_done  <= 1'b0;
         frame_abort <= 1'b0;
      end else begin
         frame_done  <= cs_rise & in_frame & full;
         frame_abort <= cs_rise & in_frame & ~full;
      end
   end

endmodule : asfi_device
`default_nettype wire

//--- logic/asfi_host.sv
// Purpose: Host end: frames one 16-bit word per request, makes the serial clock, collects the reply.
// Assumes: Serial clock is clk divided by twice ASFI_SCLK_HALF.
// Notes:   Fewer than sixteen edges gives an aborted frame.
`timescale 1ns/1ps
`default_nettype none
module asfi_host
   import asfi_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   asfi_if.host                           link,
   input  wire logic                      start,
   input  wire logic [ASFI_WORD_BITS-1:0] tx_word,
   input  wire logic [4:0]                edge_limit,
   input  wire logic                      extra_write,
   output logic                           ready,
   output logic                           busy,
   output logic      [ASFI_WORD_BITS-1:0] rx_word,
   output logic                           rx_valid
);

   asfi_hstate_t              state;
   logic [3:0]                div;
   logic [4:0]                nedge;
   logic [4:0]                limit;
   logic [ASFI_WORD_BITS-1:0] tx_sh;
   logic [ASFI_WORD_BITS-1:0] rx_sh;
   logic [7:0]                quiet_cnt;
   logic [11:0]               conv_cnt;
   logic                      sdo_s1;
   logic                      sdo_s2;
   logic                      phase_end;

   assign phase_end = (div == ASFI_SCLK_HALF - 4'h1);
   assign ready     = (state == ASFI_H_IDLE) && (extra_write || conv_cnt == 12'h000);
   assign busy      = (state != ASFI_H_IDLE);

   ////////////////////////////////////////////////////////////////////////////////
   // Reply line synchroniser

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sdo_s1 <= 1'b1;
         sdo_s2 <= 1'b1;
      end else begin
         sdo_s1 <= link.sdo_level;
         sdo_s2 <= sdo_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion spacing

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conv_cnt <= 12'h000;
      end else if (start && ready && !extra_write) begin
         conv_cnt <= 12'(ASFI_CONV_CYC - 1);
      end else if (conv_cnt != 12'h000) begin
         conv_cnt <= conv_cnt - 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame sequencer

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state     <= ASFI_H_IDLE;
         link.cs_n <= 1'b1;
         link.sclk <= 1'b1;
         link.din  <= 1'b0;
         div       <= 4'h0;
         nedge     <= 5'h00;
         limit     <= 5'h00;
         tx_sh     <= '0;
         rx_sh     <= '0;
         rx_word   <= '0;
         rx_valid  <= 1'b0;
         quiet_cnt <= 8'h00;
      end else begin
         rx_valid <= 1'b0;
         unique case (state)
            ASFI_H_IDLE: begin
               if (start && ready) begin
                  link.cs_n <= 1'b0;
                  link.din  <= tx_word[ASFI_WORD_BITS-1];
                  tx_sh     <= tx_word;
                  limit     <= edge_limit;
                  nedge     <= 5'h00;
                  div       <= 4'h0;
                  state     <= ASFI_H_HIGH;
               end
            end
            ASFI_H_HIGH: begin
               div <= phase_end ? 4'h0 : div + 4'h1;
               if (phase_end) begin
                  if (nedge == limit) begin
                     state <= ASFI_H_END;
                  end else begin
                     rx_sh     <= {rx_sh[ASFI_WORD_BITS-2:0], sdo_s2};
                     link.sclk <= 1'b0;
                     nedge     <= nedge + 5'h01;
                     state     <= ASFI_H_LOW;
                  end
               end
            end
            ASFI_H_LOW: begin
               div <= phase_end ? 4'h0 : div + 4'h1;
               if (phase_end) begin
                  link.sclk <= 1'b1;
                  link.din  <= tx_sh[ASFI_WORD_BITS-2];
                  tx_sh     <= {tx_sh[ASFI_WORD_BITS-2:0], 1'b0};
                  state     <= ASFI_H_HIGH;
               end
            end
            ASFI_H_END: begin
               link.cs_n <= 1'b1;
               if (nedge == ASFI_EDGE_LAST) begin
                  rx_word  <= rx_sh;
                  rx_valid <= 1'b1;
               end
               quiet_cnt <= 8'(ASFI_QUIET_CYC - 1);
               state     <= ASFI_H_QUIET;
            end
            ASFI_H_QUIET: begin
               quiet_cnt <= quiet_cnt - 8'h01;
               if (quiet_cnt == 8'h00) begin
                  state <= ASFI_H_IDLE;
               end
            end
            default: begin
               state <= ASFI_H_IDLE;
            end
         endcase
      end
   end

endmodule : asfi_host
`default_nettype wire

//--- sim/asfi_chk.sv
// Purpose: Wire-level checks of the serial frame link between host and converter ends.
// Assumes: Serial clock is made from clk, so link pins are sampled by clk directly.
// Notes:   The converter end reacts to pin edges a few clk cycles late.
`timescale 1ns/1ps
`default_nettype none
module asfi_chk
   import asfi_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic sdo_level
);
   // Cycles of 4 ns that cover the quiet gap
   localparam int QUIET_MIN = ASFI_QUIET_CYC;

   logic       sclk_q;
   logic       fall;
   logic [4:0] cnt;
   logic [4:0] hi_cnt;
   logic [3:0] since_fall;

   assign fall = sclk_q && !sclk;

   always_ff @(posedge clk) begin
      sclk_q <= rst_n ? sclk : 1'b1;
   end

   // Serial clock falls within the current frame
   always_ff @(posedge clk) begin
      if (!rst_n || cs_n) begin
         cnt <= 5'h00;
      end else if (fall && cnt != 5'h1F) begin
         cnt <= cnt + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || fall) begin
         since_fall <= 4'h0;
      end else if (since_fall != 4'hF) begin
         since_fall <= since_fall + 4'h1;
      end
   end

   // Idle time of select, saturated at reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hi_cnt <= 5'h1F;
      end else if (!cs_n) begin
         hi_cnt <= 5'h00;
      end else if (hi_cnt != 5'h1F) begin
         hi_cnt <= hi_cnt + 5'h01;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_zero_lead: assert property (!cs_n && cnt == 5'h00 && dout_oe |-> !dout && !sdo_level)
      else $error("leading bit not zero");
   a_float_at_16: assert property (cnt == ASFI_EDGE_LAST && $past(cnt) == 5'h0F |-> ##[1:6] !dout_oe)
      else $error("output still driven after last fall");
   a_abort_float: assert property ($rose(cs_n) && cnt < ASFI_EDGE_LAST |-> ##[1:6] !dout_oe)
      else $error("output driven after early select rise");
   a_idle_float: assert property (cs_n [*8] |-> !dout_oe)
      else $error("output driven while not selected");
   a_dout_launch: assert property ($changed(dout) && dout_oe && $past(dout_oe) |-> since_fall <= 4'h6)
      else $error("output bit changed away from a serial clock fall");
   a_sclk_idle: assert property (cs_n && $past(cs_n) |-> sclk)
      else $error("serial clock not idle high");
   a_max_falls: assert property ($rose(cs_n) |-> cnt <= ASFI_EDGE_LAST)
      else $error("more than sixteen falls in a frame");
   a_quiet_gap: assert property ($fell(cs_n) |-> hi_cnt >= QUIET_MIN)
      else $error("select reasserted inside quiet gap");
   a_din_launch: assert property (!cs_n && !$past(cs_n) && $changed(din) |-> $rose(sclk))
      else $error("input bit changed away from a rising serial clock");
   a_half_period: assert property ($fell(sclk) |-> $past(sclk, 3))
      else $error("serial clock high phase too short");
endmodule : asfi_chk
`default_nettype wire

//--- sim/testbench.sv
// Purpose: Host and converter ends joined by the link, driven through the host user port.
// Assumes: sample_data follows mux_chan, so each word carries its channel in the data field.
// Notes:   Conversions wait for host spacing; writes use the extra-write path.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import asfi_pkg::*;
;
   logic        clk;
   logic        rst_n;
   logic        start;
   logic [15:0] tx_word;
   logic [4:0]  edge_limit;
   logic        extra_write;
   logic        ready;
   logic        busy;
   logic [15:0] rx_word;
   logic        rx_valid;
   logic [11:0] sample_data;
   logic [2:0]  mux_chan;
   logic        track;
   logic [11:0] ctrl_word;
   logic [15:0] shadow_word;
   logic        seq_active;
   logic        frame_abort;
   logic        frame_done;
   logic        trk_end;
   int          bad_count;
   int          n_tests;
   int          n_abort = 0;
   int          n_done = 0;
   int          i;
   int          c;
   logic [15:0] rx;
   logic [11:0] cw;
   logic [2:0]  tag;
   logic [2:0]  prev;
   logic [4:0]  lims [3];

   asfi_if link_if ();
   asfi_device asfi_device_inst (.clk(clk), .rst_n(rst_n), .link(link_if), .sample_data(sample_data),
      .mux_chan(mux_chan), .track(track), .ctrl_word(ctrl_word), .shadow_word(shadow_word),
      .seq_active(seq_active), .frame_done(frame_done), .frame_abort(frame_abort));
   asfi_host asfi_host_inst (.clk(clk), .rst_n(rst_n), .link(link_if), .start(start), .tx_word(tx_word),
      .edge_limit(edge_limit), .extra_write(extra_write), .ready(ready), .busy(busy),
      .rx_word(rx_word), .rx_valid(rx_valid));
   asfi_chk asfi_chk_inst (.clk(clk), .rst_n(rst_n), .cs_n(link_if.cs_n), .sclk(link_if.sclk),
      .din(link_if.din), .dout(link_if.dout), .dout_oe(link_if.dout_oe), .sdo_level(link_if.sdo_level));

   always #2 clk = ~clk;

   always @(posedge clk) begin
      sample_data <= {mux_chan, 9'h15A};
      if (rx_valid === 1'b1) trk_end <= track;
      if (frame_abort === 1'b1) n_abort++;
      if (frame_done === 1'b1) n_done++;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] word_for(input logic [2:0] ch);
      return {1'b0, ch, ch, 9'h15A};
   endfunction : word_for

   function automatic logic [11:0] ctrl_for(input logic [2:0] ch, input logic [1:0] pm, input logic sq,
                                            input logic sh);
      return {1'b1, sq, sh, ch, pm, 4'h0};
   endfunction : ctrl_for

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One frame; rx stays unknown when no word came back
   task automatic xfer(input logic [15:0] tx, input logic [4:0] lim, input logic ex, output logic [15:0] r);
      int k;
      k = 0;
      r = 16'hXXXX;
      // Spacing exemption must be in place before ready is judged
      @(posedge clk);
      tx_word     <= tx;
      edge_limit  <= lim;
      extra_write <= ex;
      @(negedge clk);
      while (ready !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      do begin
         @(negedge clk);
         k++;
         if (rx_valid === 1'b1) r = rx_word;
      end while (busy !== 1'b0 && k < 6000);
      if (k >= 6000) chk(16'h0000, 16'h0001, "frame timeout");
   endtask : xfer

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #300000;
      bad_count++;
      $display("FAIL %0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      clk = 1'b0; rst_n = 1'b0; start = 1'b0; tx_word = 16'h0000; edge_limit = 5'h10;
      extra_write = 1'b0;
      bad_count = 0; n_tests = 0;
      lims = '{5'h00, 5'h01, 5'h0F};
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk({4'h0, ctrl_word}, {4'h0, ASFI_CTRL_RESET}, "control after reset");
      xfer(16'h0000, 5'h10, 1'b0, rx);
      chk(rx, word_for(3'h0), "first word");
      chk({15'h0, trk_end}, 16'h0001, "track at frame end");
      for (c = 0; c < 8; c++) begin
         cw = ctrl_for(c[2:0], ASFI_PM_NORMAL, 1'b0, 1'b0);
         xfer({cw, 4'h0}, 5'h10, 1'b1, rx);
         chk({4'h0, ctrl_word}, {4'h0, cw}, "control write");
         chk({13'h0, mux_chan}, {13'h0, c[2:0]}, "channel select");
         xfer(16'h0000, 5'h10, 1'b0, rx);
         chk(rx, word_for(c[2:0]), "channel tag");
         chk({4'h0, ctrl_word}, {4'h0, cw}, "dummy keeps control");
      end
      for (i = 0; i < 3; i++) begin
         xfer({ctrl_for(3'h2, ASFI_PM_NORMAL, 1'b0, 1'b0), 4'h0}, lims[i], 1'b1, rx);
         chk({4'h0, ctrl_word}, {4'h0, cw}, "abort keeps control");
         chk(rx, 16'hXXXX, "abort returns no word");
      end
      chk(n_abort[15:0], 16'h0003, "abort pulses");
      cw = ctrl_for(3'h1, ASFI_PM_FULL, 1'b0, 1'b0);
      xfer({cw, 4'h0}, 5'h10, 1'b1, rx);
      xfer(16'h0000, 5'h10, 1'b0, rx);
      chk(rx, 16'hFFFF, "shutdown frame undriven");
      cw = ctrl_for(3'h1, ASFI_PM_NORMAL, 1'b0, 1'b0);
      xfer({cw, 4'h0}, 5'h10, 1'b1, rx);
      chk(rx, 16'hFFFF, "power-up write undriven");
      xfer(16'h0000, 5'h10, 1'b0, rx);
      chk(rx, word_for(3'h1), "valid after power-up");
      cw = ctrl_for(3'h0, ASFI_PM_NORMAL, 1'b1, 1'b1);
      xfer({cw, 4'h0}, 5'h10, 1'b1, rx);
      xfer(16'h8100, 5'h10, 1'b0, rx);
      chk(shadow_word, 16'h8100, "shadow load");
      chk({15'h0, seq_active}, 16'h0001, "sequence on");
      chk({15'h0, trk_end}, 16'h0000, "hold until select rise");
      prev = 3'h4;
      for (i = 0; i < 4; i++) begin
         xfer(16'h0000, 5'h10, 1'b0, rx);
         tag = rx[14:12];
         chk(rx, word_for(tag), "sequence word");
         chk({15'h0, (tag == 3'h0 || tag == 3'h7) && tag != prev}, 16'h0001, "sequence step");
         prev = tag;
      end
      chk(n_done[15:0], 16'h001B, "full frames");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
